// >>> sce_pkg.sv
/*
 package for the serial channel event and modem handshake block.
 assumes: one 20 MHz clock, register port with one-cycle strobes.
*/
package sce_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int EVW = 16;
    localparam int STW = 8;
    localparam logic [3:0] ADDR_EVENTS = 4'h0;
    localparam logic [3:0] ADDR_ENABLE = 4'h1;
    localparam logic [3:0] ADDR_LINE = 4'h2;
    localparam logic [3:0] ADDR_MODE = 4'h3;
    localparam logic [3:0] ADDR_MODSTAT = 4'h4;
    // mode register fields
    localparam int MODE_TX_EN = 0;
    localparam int MODE_RX_EN = 1;
    localparam int MODE_CTS_DIRECT = 2;
    localparam int MODE_CD_DIRECT = 3;
    localparam int MODE_CTS_PULSE = 4;
    localparam int MODE_CD_PULSE = 5;
    localparam int MODE_ASYNC = 6;
    localparam int MODE_DIAGNOSTIC_LO = 7;
    localparam int MODE_TX_CLK_INV = 9;
    localparam logic [1:0] DIAGNOSTIC_NORMAL = 2'h0;
    // event bit positions
    localparam int EV_CTS_LOST = 0;
    localparam int EV_CD_LOST = 1;
    localparam int EV_TX_DONE = 2;
    localparam int EV_RX_DONE = 3;
    // asynchronous start delays in bit times
    localparam logic [1:0] ASYNC_DELAY_READY = 2'h2;
    localparam logic [1:0] ASYNC_DELAY_SAMPLED = 2'h3;
    typedef enum {TX_IDLE, TX_WAIT, TX_DELAY, TX_SEND, TX_TAIL} sce_tx_state_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } sce_bus_t;
    typedef struct packed {
        logic txClk;
        logic rxClk;
        logic ctsN;
        logic cdN;
    } sce_pins_t;
endpackage

// >>> sce_sync.sv
/*
 two-flop synchroniser with edge detection behind the second flop.
 assumes: input is asynchronous to clk.
*/
module sce_sync
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // signal
    input wire logic din,
    output logic dout,
    output logic rise,
    output logic fall
);
    logic meta;
    logic stage;
    logic prev;
    // edges held back until prev holds a real sample: a pin idling low
    // would otherwise show a false fall right after reset
    logic [2:0] filled;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta <= 1'b1;
            stage <= 1'b1;
            prev <= 1'b1;
            filled <= '0;
        end
        else
        begin
            meta <= din;
            stage <= meta;
            prev <= stage;
            filled <= {filled[1:0], 1'b1};
        end
    end
    assign dout = stage;
    assign rise = filled[2] & stage & ~prev;
    assign fall = filled[2] & ~stage & prev;
endmodule // sce_sync

// >>> sce_events.sv
/*
 event flags with write-one-to-clear and enable mask.
 assumes: event pulses come from logic on clk.
*/
module sce_events #(
    parameter int W = 16
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // events and control
    input wire logic [W-1:0] evSet,
    input wire logic [W-1:0] clrMask,
    input wire logic clrWr,
    input wire logic [W-1:0] enable,
    // result
    output logic [W-1:0] flags,
    output logic irq
);
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            flags <= '0;
        else
            // set wins over a simultaneous clear
            flags <= (flags & ~(clrWr ? clrMask : '0)) | evSet;
    end
    assign irq = |(flags & enable);

    a_flag_sets: assert property (@(posedge clk) disable iff (!rst_n)
        |evSet |=> ((flags & $past(evSet)) == $past(evSet)))
        else $error("event flag not set");
    a_clear_only: assert property (@(posedge clk) disable iff (!rst_n)
        (clrWr && evSet == '0) |=> (flags == ($past(flags) & ~$past(clrMask))))
        else $error("write one clear wrong");
    a_irq_masked: assert property (@(posedge clk) disable iff (!rst_n)
        ((flags & enable) == '0) |-> !irq)
        else $error("masked event raised request");
endmodule // sce_events

// >>> sce_channel.sv
/*
 serial channel event reporting and automatic modem handshake.
 assumes: handshake pins and serial clocks are asynchronous and far slower
 than clk; the transmit and receive data paths supply fifo-loaded and last-bit signals.
*/
// Design decisions made here: strobed register access and the address map.
module sce_channel #(
    parameter int EVW = sce_pkg::EVW,
    parameter int STW = sce_pkg::STW
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire sce_pkg::sce_bus_t bus,
    output logic [15:0] rdata,
    // link pins
    input wire sce_pkg::sce_pins_t pins,
    output logic rtsN,
    output logic txGate,
    output logic txIdle,
    output logic rxGate,
    // data path status
    input wire logic fifoLoaded,
    input wire logic lastTxBit,
    input wire logic lastRxBit,
    input wire logic [STW-1:0] lineStatus,
    input wire logic [EVW-1:0] protoEvents,
    // module interrupt side
    input wire logic moduleMaskEn,
    output logic pendingSet,
    output logic cpuIrq,
    output logic cdLostFlag
);
    logic [EVW-1:0] enable;
    logic [EVW-1:0] flags;
    logic [EVW-1:0] evSet;
    logic [15:0] mode;
    logic [STW-1:0] lineReg;
    logic chanIrq;
    logic txRise, txFall;
    logic rxRise;
    logic clear_to_send_direct_select;
    logic carrier_detect_direct_select;
    logic autoMode;
    logic ctsDirect, cdDirect, cdPulse, asyncMode;
    logic ctsOk;
    logic cdOk;
    logic ctsLostEv, cdLostEv, txDoneEv, rxDoneEv;
    logic rxActive;
    logic [1:0] bitCnt;
    sce_pkg::sce_tx_state_t state;

    sce_sync uTxc (.clk(clk), .rst_n(rst_n), .din(pins.txClk), .dout(),
        .rise(txRise), .fall(txFall));
    sce_sync uRxc (.clk(clk), .rst_n(rst_n), .din(pins.rxClk), .dout(),
        .rise(rxRise), .fall());
    sce_sync uCts (.clk(clk), .rst_n(rst_n), .din(pins.ctsN), .dout(clear_to_send_direct_select),
        .rise(), .fall());
    sce_sync uCd (.clk(clk), .rst_n(rst_n), .din(pins.cdN), .dout(carrier_detect_direct_select),
        .rise(), .fall());

    assign ctsDirect = mode[sce_pkg::MODE_CTS_DIRECT];
    assign cdDirect = mode[sce_pkg::MODE_CD_DIRECT];
    assign cdPulse = mode[sce_pkg::MODE_CD_PULSE];
    assign asyncMode = mode[sce_pkg::MODE_ASYNC];
    // timing assumes the transmit clock is not inverted
    assign autoMode = (mode[sce_pkg::MODE_DIAGNOSTIC_LO +: 2] == sce_pkg::DIAGNOSTIC_NORMAL)
        && !mode[sce_pkg::MODE_TX_CLK_INV];

    // register writes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            enable <= '0;
            mode <= 16'h0000;
            lineReg <= '0;
        end
        else if (bus.wr)
        begin
            if (bus.addr == sce_pkg::ADDR_ENABLE)
                enable <= bus.wdata[EVW-1:0];
            else if (bus.addr == sce_pkg::ADDR_MODE)
                mode <= bus.wdata;
            else if (bus.addr == sce_pkg::ADDR_LINE)
                lineReg <= bus.wdata[STW-1:0];
        end
        else
            lineReg <= lineStatus;
    end

    // register reads, data one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rdata <= 16'h0000;
        else if (bus.rd)
        begin
            if (bus.addr == sce_pkg::ADDR_EVENTS)
                rdata <= flags;
            else if (bus.addr == sce_pkg::ADDR_ENABLE)
                rdata <= enable;
            else if (bus.addr == sce_pkg::ADDR_LINE)
                rdata <= {{(16 - STW){1'b0}}, lineReg};
            else if (bus.addr == sce_pkg::ADDR_MODE)
                rdata <= mode;
            else if (bus.addr == sce_pkg::ADDR_MODSTAT)
                rdata <= {11'h000, rxActive, cdOk, ctsOk, ~clear_to_send_direct_select, ~carrier_detect_direct_select};
            else
                rdata <= 16'h0000;
        end
        else
            rdata <= 16'h0000;
    end

    always_comb
    begin
        evSet = protoEvents;
        evSet[sce_pkg::EV_CTS_LOST] = protoEvents[sce_pkg::EV_CTS_LOST] | ctsLostEv;
        evSet[sce_pkg::EV_CD_LOST] = protoEvents[sce_pkg::EV_CD_LOST] | cdLostEv;
        evSet[sce_pkg::EV_TX_DONE] = protoEvents[sce_pkg::EV_TX_DONE] | txDoneEv;
        evSet[sce_pkg::EV_RX_DONE] = protoEvents[sce_pkg::EV_RX_DONE] | rxDoneEv;
    end

    sce_events #(.W(EVW)) uEv (.clk(clk), .rst_n(rst_n), .evSet(evSet),
        .clrMask(bus.wdata[EVW-1:0]),
        .clrWr(bus.wr && bus.addr == sce_pkg::ADDR_EVENTS), .enable(enable),
        .flags(flags), .irq(chanIrq));

    assign pendingSet = chanIrq;
    assign cpuIrq = chanIrq & moduleMaskEn;

    // clear-to-send view: direct follows the pin, sampled waits for a rising
    // transmit clock, giving the half to one bit delay
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ctsOk <= 1'b0;
        else if (ctsDirect)
            ctsOk <= ~clear_to_send_direct_select;
        else if (txRise)
            ctsOk <= ~clear_to_send_direct_select;
    end

    // transmit handshake
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= sce_pkg::TX_IDLE;
            rtsN <= 1'b1;
            bitCnt <= 2'h0;
            ctsLostEv <= 1'b0;
            txDoneEv <= 1'b0;
        end
        else
        begin
            ctsLostEv <= 1'b0;
            txDoneEv <= 1'b0;
            case (state)
                sce_pkg::TX_IDLE:
                    if (autoMode && mode[sce_pkg::MODE_TX_EN] && fifoLoaded && txFall)
                    begin
                        rtsN <= 1'b0;
                        if (asyncMode)
                        begin
                            state <= sce_pkg::TX_DELAY;
                            bitCnt <= (ctsOk || ctsDirect) ? sce_pkg::ASYNC_DELAY_READY
                                : sce_pkg::ASYNC_DELAY_SAMPLED;
                        end
                        else
                            state <= ctsOk ? sce_pkg::TX_SEND : sce_pkg::TX_WAIT;
                    end
                sce_pkg::TX_WAIT:
                    if (ctsOk)
                        state <= sce_pkg::TX_SEND;
                sce_pkg::TX_DELAY:
                    if (txFall)
                    begin
                        // a late clear-to-send waits; loss only counts once sending
                        if (bitCnt == 2'h1)
                            state <= ctsOk ? sce_pkg::TX_SEND : sce_pkg::TX_WAIT;
                        bitCnt <= bitCnt - 2'h1;
                    end
                sce_pkg::TX_SEND:
                    if (!ctsOk)
                    begin
                        rtsN <= 1'b1;
                        ctsLostEv <= 1'b1;
                        state <= sce_pkg::TX_IDLE;
                    end
                    else if (lastTxBit)
                        state <= sce_pkg::TX_TAIL;
                sce_pkg::TX_TAIL:
                    if (txFall)
                    begin
                        rtsN <= 1'b1;
                        txDoneEv <= 1'b1;
                        state <= sce_pkg::TX_IDLE;
                    end
                default:
                    state <= sce_pkg::TX_IDLE;
            endcase
        end
    end
    // first bit out is the flag, sync, preamble or start bit of the data path
    assign txGate = (state == sce_pkg::TX_SEND) && ctsOk;
    assign txIdle = !txGate;

    // carrier detect view
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cdOk <= 1'b0;
        else if (cdDirect)
            cdOk <= ~carrier_detect_direct_select;
        else if (rxRise)
            cdOk <= ~carrier_detect_direct_select;
    end

    // reception gating and carrier loss
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rxActive <= 1'b0;
            cdLostEv <= 1'b0;
            cdLostFlag <= 1'b0;
            rxDoneEv <= 1'b0;
        end
        else
        begin
            cdLostEv <= 1'b0;
            rxDoneEv <= 1'b0;
            if (!(autoMode && mode[sce_pkg::MODE_RX_EN]))
                rxActive <= 1'b0;
            else if (!rxActive && cdOk)
            begin
                rxActive <= 1'b1;
                cdLostFlag <= 1'b0;
            end
            else if (rxActive && lastRxBit)
            begin
                rxActive <= 1'b0;
                rxDoneEv <= 1'b1;
            end
            // pulse mode: carrier only starts reception
            else if (rxActive && !cdOk && !cdPulse)
            begin
                rxActive <= 1'b0;
                cdLostEv <= 1'b1;
                cdLostFlag <= 1'b1;
            end
        end
    end
    assign rxGate = rxActive;

    a_cts_lost: assert property (@(posedge clk) disable iff (!rst_n)
        (state == sce_pkg::TX_SEND && !ctsOk) |=> (rtsN && ctsLostEv))
        else $error("cts loss not handled");
    a_rts_tail: assert property (@(posedge clk) disable iff (!rst_n)
        (state == sce_pkg::TX_TAIL && txFall) |=> rtsN)
        else $error("rts not dropped after frame");
    a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
        cpuIrq |-> (moduleMaskEn && pendingSet))
        else $error("interrupt not gated by module mask");
    a_rts_auto: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(rtsN)) |-> $past(autoMode))
        else $error("rts raised outside normal mode");
    a_cd_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        cdPulse |-> !cdLostEv)
        else $error("carrier lost in pulse mode");
    a_rts_cause: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(rtsN) |-> $past(fifoLoaded && txFall && mode[sce_pkg::MODE_TX_EN]))
        else $error("rts asserted without loaded data and falling clock");
    a_cd_lost_end: assert property (@(posedge clk) disable iff (!rst_n)
        cdLostEv |-> !rxActive)
        else $error("reception continues after carrier loss");
    c_tx_frame: cover property (@(posedge clk) disable iff (!rst_n) txDoneEv);
    c_cts_lost: cover property (@(posedge clk) disable iff (!rst_n) ctsLostEv);
    c_cd_lost: cover property (@(posedge clk) disable iff (!rst_n) cdLostEv);
    c_rx_frame: cover property (@(posedge clk) disable iff (!rst_n) rxDoneEv);
    c_async_send: cover property (@(posedge clk) disable iff (!rst_n) asyncMode && txGate);
endmodule // sce_channel

// >>> sce_modem.sv
/*
 modem model: serial clocks and handshake lines at the far side.
 assumes: the bench commands clock run, clear-to-send and carrier levels.
*/
module sce_modem
(
    // commands from the bench
    input wire logic run,
    input wire logic ctsOn,
    input wire logic cdOn,
    // link pins
    output sce_pkg::sce_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic linkClk = 1'b0;
    logic ctsN = 1'b1;
    logic cdN = 1'b1;
    // odd start offset keeps link edges off the system clock edges
    initial
    begin
        #13;
        forever
        begin
            #200;
            linkClk = run ? ~linkClk : 1'b0;
        end
    end
    // lines only move while the clock is low, as direct mode needs
    always @(linkClk or ctsOn or cdOn)
        if (!linkClk)
        begin
            ctsN = !ctsOn;
            cdN = !cdOn;
        end
    assign pins = '{txClk: linkClk, rxClk: linkClk, ctsN: ctsN, cdN: cdN};
endmodule // sce_modem

// >>> serial_channel_events_modem_handshake_tb.sv
/*
 testbench for the channel event and handshake block.
 assumes: sce_pkg, sce_channel and the modem model are compiled first.
*/
module serial_channel_events_modem_handshake_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    sce_pkg::sce_bus_t bus = '0;
    sce_pkg::sce_pins_t pins;
    logic [15:0] rdata;
    logic rtsN, txGate, txIdle, rxGate, pendingSet, cpuIrq, cdLostFlag;
    logic fifoLoaded = 1'b0;
    logic lastTxBit = 1'b0;
    logic lastRxBit = 1'b0;
    logic [7:0] lineStatus = 8'h00;
    logic [15:0] protoEvents = 16'h0000;
    logic moduleMaskEn = 1'b0;
    logic linkRun = 1'b0;
    logic ctsOn = 1'b0;
    logic cdOn = 1'b0;
    int errors = 0;
    int nCompared = 0;
    always #25 clk = ~clk;
    sce_channel u_sce_channel (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .pins(pins), .rtsN(rtsN), .txGate(txGate), .txIdle(txIdle), .rxGate(rxGate),
        .fifoLoaded(fifoLoaded), .lastTxBit(lastTxBit), .lastRxBit(lastRxBit),
        .lineStatus(lineStatus), .protoEvents(protoEvents), .moduleMaskEn(moduleMaskEn),
        .pendingSet(pendingSet), .cpuIrq(cpuIrq), .cdLostFlag(cdLostFlag));
    sce_modem u_sce_modem (.run(linkRun), .ctsOn(ctsOn), .cdOn(cdOn), .pins(pins));
    task automatic results();
        if (errors == 0 && nCompared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic wrReg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rdReg(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask
    // bounded wait on rtsN (0), txGate (1) or rxGate (2)
    task automatic waitSig(input int which, input logic val, input int bound);
        int i;
        for (i = 0; i < bound; i++)
        begin
            @(posedge clk);
            #1;
            if ((which == 0 ? rtsN : which == 1 ? txGate : rxGate) === val)
                break;
        end
        if (i == bound)
        begin
            errors++;
            $display("[FAIL] t=%0t wait on %h never reached %h", $time, which, val);
            results();
        end
    endtask
    task automatic pulse(input int which);
        @(posedge clk);
        if (which == 0) lastTxBit <= 1'b1; else lastRxBit <= 1'b1;
        @(posedge clk);
        lastTxBit <= 1'b0;
        lastRxBit <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdReg(sce_pkg::ADDR_EVENTS, 16'h0000);
        rdReg(sce_pkg::ADDR_ENABLE, 16'h0000);
        rdReg(4'hF, 16'h0000);
        lineStatus <= 8'hA5;
        cdOn <= 1'b1;
        rdReg(sce_pkg::ADDR_LINE, 16'h00A5);
        cdOn <= 1'b0;
        @(posedge clk);
        protoEvents <= 16'h0500;
        @(posedge clk);
        protoEvents <= 16'h0000;
        rdReg(sce_pkg::ADDR_EVENTS, 16'h0500);
        check({15'h0, pendingSet}, 16'h0000);
        wrReg(sce_pkg::ADDR_ENABLE, 16'h0200);
        settle(2);
        check({15'h0, pendingSet}, 16'h0000);
        wrReg(sce_pkg::ADDR_ENABLE, 16'h0100);
        rdReg(sce_pkg::ADDR_ENABLE, 16'h0100);
        settle(2);
        check({15'h0, pendingSet}, 16'h0001);
        check({15'h0, cpuIrq}, 16'h0000);
        moduleMaskEn <= 1'b1;
        settle(2);
        check({15'h0, cpuIrq}, 16'h0001);
        wrReg(sce_pkg::ADDR_EVENTS, 16'h0000);
        rdReg(sce_pkg::ADDR_EVENTS, 16'h0500);
        wrReg(sce_pkg::ADDR_EVENTS, 16'h0400);
        settle(2);
        check({15'h0, pendingSet}, 16'h0001);
        wrReg(sce_pkg::ADDR_EVENTS, 16'h0500);
        rdReg(sce_pkg::ADDR_EVENTS, 16'h0000);
        settle(2);
        check({15'h0, pendingSet}, 16'h0000);
        wrReg(sce_pkg::ADDR_ENABLE, 16'h000F);
        linkRun <= 1'b1;
        // sampled then direct clear-to-send: ready frame, then late start and loss
        for (int d = 0; d < 2; d++)
        begin
            ctsOn <= 1'b1;
            wrReg(sce_pkg::ADDR_MODE, 16'h0003 | 16'(d << 2));
            settle(40);
            fifoLoaded <= 1'b1;
            waitSig(0, 1'b0, 40);
            waitSig(1, 1'b1, 3);
            check({15'h0, txIdle}, 16'h0000);
            fifoLoaded <= 1'b0;
            pulse(0);
            waitSig(0, 1'b1, 20);
            rdReg(sce_pkg::ADDR_EVENTS, 16'h0004);
            wrReg(sce_pkg::ADDR_EVENTS, 16'hFFFF);
            ctsOn <= 1'b0;
            settle(40);
            fifoLoaded <= 1'b1;
            waitSig(0, 1'b0, 40);
            settle(20);
            check({15'h0, txGate}, 16'h0000);
            ctsOn <= 1'b1;
            waitSig(1, 1'b1, d ? 12 : 22);
            ctsOn <= 1'b0;
            fifoLoaded <= 1'b0;
            waitSig(0, 1'b1, d ? 12 : 22);
            check({15'h0, txIdle}, 16'h0001);
            rdReg(sce_pkg::ADDR_EVENTS, 16'h0001);
            wrReg(sce_pkg::ADDR_EVENTS, 16'hFFFF);
        end
        ctsOn <= 1'b1;
        wrReg(sce_pkg::ADDR_MODE, 16'h0083);
        rdReg(sce_pkg::ADDR_MODE, 16'h0083);
        fifoLoaded <= 1'b1;
        settle(60);
        check({15'h0, rtsN}, 16'h0001);
        fifoLoaded <= 1'b0;
        wrReg(sce_pkg::ADDR_MODE, 16'h0043);
        fifoLoaded <= 1'b1;
        waitSig(0, 1'b0, 40);
        settle(6);
        check({15'h0, txGate}, 16'h0000);
        waitSig(1, 1'b1, 26);
        fifoLoaded <= 1'b0;
        pulse(0);
        waitSig(0, 1'b1, 20);
        // sampled mode with clear-to-send off at request: three bit times
        ctsOn <= 1'b0;
        settle(40);
        fifoLoaded <= 1'b1;
        waitSig(0, 1'b0, 40);
        ctsOn <= 1'b1;
        settle(18);
        check({15'h0, txGate}, 16'h0000);
        waitSig(1, 1'b1, 14);
        fifoLoaded <= 1'b0;
        pulse(0);
        waitSig(0, 1'b1, 20);
        // carrier: sampled, direct, then pulse mode where loss is ignored
        for (int d = 0; d < 3; d++)
        begin
            wrReg(sce_pkg::ADDR_MODE, d == 2 ? 16'h0023 : 16'h0003 | 16'(d << 3));
            wrReg(sce_pkg::ADDR_EVENTS, 16'hFFFF);
            cdOn <= 1'b1;
            waitSig(2, 1'b1, 30);
            check({15'h0, cdLostFlag}, 16'h0000);
            cdOn <= 1'b0;
            if (d == 2)
            begin
                settle(30);
                check({15'h0, rxGate}, 16'h0001);
                rdReg(sce_pkg::ADDR_MODSTAT, 16'h0016);
                pulse(1);
                waitSig(2, 1'b0, 10);
                rdReg(sce_pkg::ADDR_EVENTS, 16'h0008);
            end
            else
            begin
                waitSig(2, 1'b0, d ? 12 : 22);
                check({15'h0, cdLostFlag}, 16'h0001);
                rdReg(sce_pkg::ADDR_EVENTS, 16'h0002);
            end
        end
        linkRun <= 1'b0;
        results();
    end
endmodule // serial_channel_events_modem_handshake_tb
